// *** rtl/dtp_terminal_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtp_terminal_regs
   import dtp_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   resetn,
   // network holding-register access
   input  wire logic                   netReq,
   input  wire logic                   netWrite,
   input  wire logic [15:0]            netAddr,
   input  wire logic [15:0]            netWrData,
   output logic                        netAck,
   output logic      [15:0]            netRdData,
   output logic      [7:0]             netExcept,

   // local keypad access
   input  wire logic                   kpReq,
   input  wire logic                   kpWrite,
   input  wire logic [15:0]            kpAddr,
   input  wire logic [15:0]            kpWrData,
   output logic      [15:0]            kpRdData,

   // overload and arrival
   input  wire logic [15:0]            motorCurrent,
   output logic                        overloadSignal,
   input  wire logic [15:0]            outputFreq,
   input  wire logic                   accelerating,
   input  wire logic                   decelerating,
   output logic                        arrivalSignal,

   // loop supervision
   input  wire logic [15:0]            loopSetpoint,
   input  wire logic [15:0]            processFeedback,
   output logic                        deviationSignal,
   output logic                        secondStageOut,

   // analog calibration
   input  wire logic [15:0]            voltageFreqIn,
   input  wire logic [15:0]            currentFreqInput,
   output logic      [15:0]            voltageFreqCmd,
   output logic      [15:0]            currentFreqCmd,
   input  wire logic [15:0]            thermalIn,
   output logic      [15:0]            thermalTuned,
   input  wire logic [15:0]            monitorIn,
   output logic      [15:0]            analogMonitorOutput,

   // setpoint memory
   input  wire logic                   powerUp,
   input  wire logic [15:0]            defaultFrequencySetting,
   input  wire logic [1:0]             incrementDecrementInputs,
   output logic      [15:0]            freqSetpoint,

   // trip clear
   input  wire logic                   resetPin,
   input  wire logic                   runMode,
   output logic                        tripClear,
   output logic                        runStop,

   // logic output operands
   input  wire logic [NUM_SOURCES-1:0] logicSources,
   output logic                        operandA,
   output logic                        operandB
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [NUM_REGS-1:0][15:0] regs;

      logic                      netAck;
      logic [15:0]               netRdData;
      logic [7:0]                netExcept;

      logic [15:0]               kpRdData;

      logic                      overload;
      logic                      arrival;
      logic                      deviation;
      logic                      secondStage;

      logic [15:0]               monitorOut;
      logic [15:0]               freqSetpoint;

      logic                      tripClear;
      logic                      runStop;

      logic                      operandA;
      logic                      operandB;
   } dtp_regs_state_t;

   dtp_regs_state_t q;
   dtp_regs_state_t d;

   // top bit of a lookup says the address is mapped
   logic [IDX_W:0]   netLook;
   logic [IDX_W:0]   kpLook;
   logic [IDX_W-1:0] netIdx;
   logic [IDX_W-1:0] kpIdx;

   // one bit wider so the sign survives
   logic [16:0]      loopError;
   logic [16:0]      loopMag;

   // one bit wider so clipping sees the carry
   logic [16:0]      monSum;

   // bit 2 reset input, bit 1 down, bit 0 up
   logic [2:0]       pinLevel;
   logic [2:0]       pinRise;
   logic [2:0]       pinFall;

   logic             clearEdge;

   // ---------------------------------------------------------------
   // address decode, shared by network and keypad ports
   // ---------------------------------------------------------------
   function automatic logic [IDX_W:0] lookUp(input logic [15:0] addr);
      logic [IDX_W:0] res;
      res = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (REG_ADDR[i] == addr) begin
            res = {1'b1, i[IDX_W-1:0]};
         end
      end
      return res;
   endfunction

   function automatic logic isLinkReg(input logic [IDX_W-1:0] idx);
      return (idx >= IDX_LINK_LO) && (idx <= IDX_LINK_HI);
   endfunction

   function automatic logic inRange(input logic [IDX_W-1:0] idx, input logic [15:0] val);
      return val <= REG_MAX[idx];
   endfunction

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // pins cross into this domain through three flops
   dtp_pin_sync #(
      .WIDTH (3)
   ) u_pin_sync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .pinIn    ({resetPin, incrementDecrementInputs}),
      .level    (pinLevel),
      .rise     (pinRise),
      .fall     (pinFall)
   );

   dtp_span_scale u_volt_scale (
      .core_clk (core_clk),
      .resetn   (resetn),
      .inVal    (voltageFreqIn),
      .span     (q.regs[IDX_V_SPAN]),
      .scaled   (voltageFreqCmd)
   );

   dtp_span_scale u_curr_scale (
      .core_clk (core_clk),
      .resetn   (resetn),
      .inVal    (currentFreqInput),
      .span     (q.regs[IDX_I_SPAN]),
      .scaled   (currentFreqCmd)
   );

   dtp_span_scale u_therm_scale (
      .core_clk (core_clk),
      .resetn   (resetn),
      .inVal    (thermalIn),
      .span     (q.regs[IDX_THERM]),
      .scaled   (thermalTuned)
   );

   assign netLook = lookUp(netAddr);
   assign kpLook  = lookUp(kpAddr);
   assign netIdx  = netLook[IDX_W-1:0];
   assign kpIdx   = kpLook[IDX_W-1:0];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      d           = q;
      d.netAck    = netReq;
      d.netExcept = EXC_NONE;
      d.tripClear = 1'b0;
      d.runStop   = 1'b0;

      loopError   = 17'({1'b0, loopSetpoint}) - 17'({1'b0, processFeedback});
      loopMag     = loopError[16] ? (17'h0 - loopError) : loopError;
      monSum      = 17'(monitorIn) + 17'(q.regs[IDX_AM_OFS]);
      clearEdge   = 1'b0;

      // network port: answered one cycle after the request
      if (netReq) begin
         if (!netLook[IDX_W] || isLinkReg(netIdx)) begin
            d.netExcept = EXC_ADDR;
            d.netRdData = 16'h0000;
         end else if (netWrite) begin
            d.netRdData = netWrData;
            if (netIdx == IDX_DEBUG) begin
               d.netExcept = EXC_FUNC;
            end else if (!inRange(netIdx, netWrData)) begin
               d.netExcept = EXC_VALUE;
            end else begin
               d.regs[netIdx] = netWrData;
            end
         end else begin
            d.netRdData = q.regs[netIdx];
         end
      end

      // keypad reaches every register, link settings included
      // applied after the network port, so keypad wins a same-edge write
      if (kpReq && kpLook[IDX_W]) begin
         d.kpRdData = q.regs[kpIdx];
         if (kpWrite && inRange(kpIdx, kpWrData)) begin
            d.regs[kpIdx] = kpWrData;
         end
      end else if (kpReq) begin
         d.kpRdData = 16'h0000;
      end

      // overload and arrival
      d.overload = motorCurrent > q.regs[IDX_OVERLOAD];

      d.arrival  = (accelerating && (outputFreq >= q.regs[IDX_ARR_ACC])) ||
                   (decelerating && (outputFreq <= q.regs[IDX_ARR_DEC]));

      // loop supervision; between the limits the output holds
      d.deviation = loopMag > 17'(q.regs[IDX_DEVIATE]);

      if (processFeedback > q.regs[IDX_FB_HIGH]) begin
         d.secondStage = 1'b0;
      end else if (processFeedback < q.regs[IDX_FB_LOW]) begin
         d.secondStage = 1'b1;
      end

      // monitor offset, clipped at full scale
      if (monSum > 17'(MON_FULL)) begin
         d.monitorOut = MON_FULL;
      end else begin
         d.monitorOut = monSum[15:0];
      end

      // setpoint memory: power-up decides, then up/down adjusts
      // up wins over down when both edges land together, unless the setpoint is already at FREQ_MAX
      if (powerUp) begin
         if (q.regs[IDX_MEM_MODE] != MEM_KEEP) begin
            d.freqSetpoint = defaultFrequencySetting;
         end
      end else if (pinRise[0] && (q.freqSetpoint < FREQ_MAX)) begin
         d.freqSetpoint = q.freqSetpoint + 16'h0001;
      end else if (pinRise[1] && (q.freqSetpoint != 16'h0000)) begin
         d.freqSetpoint = q.freqSetpoint - 16'h0001;
      end

      // trip clear on the edge the mode selects
      case (q.regs[IDX_CLR_MODE])
         CLR_RISE_STOP: begin
            clearEdge = pinRise[2];
            d.runStop = pinRise[2] && runMode;
         end
         CLR_FALL_STOP: begin
            clearEdge = pinFall[2];
            d.runStop = pinFall[2] && runMode;
         end
         CLR_RISE_RUN: begin
            clearEdge = pinRise[2];
         end
         default: begin
            clearEdge = 1'b0;
         end
      endcase

      d.tripClear = clearEdge;

      // operand selection; codes are range checked on write
      d.operandA = logicSources[q.regs[IDX_OPER_A][3:0]];
      d.operandB = logicSources[q.regs[IDX_OPER_B][3:0]];
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         for (int i = 0; i < NUM_REGS; i++) begin
            q.regs[i] <= REG_RESET;
         end
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign netAck              = q.netAck;
   assign netRdData           = q.netRdData;
   assign netExcept           = q.netExcept;

   assign kpRdData            = q.kpRdData;

   assign overloadSignal      = q.overload;
   assign arrivalSignal       = q.arrival;
   assign deviationSignal     = q.deviation;
   assign secondStageOut      = q.secondStage;

   assign analogMonitorOutput = q.monitorOut;
   assign freqSetpoint        = q.freqSetpoint;

   assign tripClear           = q.tripClear;
   assign runStop             = q.runStop;

   assign operandA            = q.operandA;
   assign operandB            = q.operandB;

endmodule // dtp_terminal_regs
`default_nettype wire

// *** shared/dtp_pkg.sv ***
// Behaviour
// - overload level 0..20000 (0.01 % steps); overload flag when current exceeds it
// - separate accel and decel arrival thresholds, each 0..4000 in 0.1 Hz
// - deviation level 0..1000; flag when |setpoint - feedback| exceeds it
// - feedback above high limit (0..1000) turns second-stage output off
// - feedback below low limit (0..1000) turns second-stage output on
// - link settings are keypad-only; network access to them is refused
// - voltage span 0..2000 scales voltage frequency command, 0.1 % steps
// - current span 0..2000 scales current frequency command, 0.1 % steps
// - thermistor tuning accepts 0..2000, meaning 0.0 to 200.0 percent
// - monitor offset accepts 0..100, 0.1 V steps, up to 10.0 V
// - after power-up, mode 00 restores default setpoint, 01 keeps adjusted one
// - reset mode 00 rise clears+stops, 01 fall clears+stops, 02 rise clears only
// - operand A select accepts 0..9, operand B select accepts its listed codes
package dtp_pkg;
   localparam int NUM_REGS = 22;
   localparam int IDX_W    = 5;
   localparam logic [15:0] REG_RESET = 16'h0000;
   // ---------------------------------------------------------------
   // register indices, offsets, limits
   // ---------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_OVERLOAD = 5'h00;
   localparam logic [IDX_W-1:0] IDX_ARR_ACC  = 5'h01;
   localparam logic [IDX_W-1:0] IDX_ARR_DEC  = 5'h02;
   localparam logic [IDX_W-1:0] IDX_DEVIATE  = 5'h03;
   localparam logic [IDX_W-1:0] IDX_FB_HIGH  = 5'h04;
   localparam logic [IDX_W-1:0] IDX_FB_LOW   = 5'h05;
   localparam logic [IDX_W-1:0] IDX_LINK_LO  = 5'h06;
   localparam logic [IDX_W-1:0] IDX_LINK_HI  = 5'h0c;
   localparam logic [IDX_W-1:0] IDX_V_SPAN   = 5'h0d;
   localparam logic [IDX_W-1:0] IDX_I_SPAN   = 5'h0e;
   localparam logic [IDX_W-1:0] IDX_THERM    = 5'h0f;
   localparam logic [IDX_W-1:0] IDX_AM_OFS   = 5'h10;
   localparam logic [IDX_W-1:0] IDX_DEBUG    = 5'h11;
   localparam logic [IDX_W-1:0] IDX_MEM_MODE = 5'h12;
   localparam logic [IDX_W-1:0] IDX_CLR_MODE = 5'h13;
   localparam logic [IDX_W-1:0] IDX_OPER_A   = 5'h14;
   localparam logic [IDX_W-1:0] IDX_OPER_B   = 5'h15;
   localparam logic [NUM_REGS-1:0][15:0] REG_ADDR = {
      16'h1151, 16'h1150, 16'h114a, 16'h1149, 16'h1148, 16'h1145,
      16'h1144, 16'h1142, 16'h1141, 16'h113f, 16'h113e, 16'h113d,
      16'h113c, 16'h113b, 16'h1139, 16'h1138, 16'h112f, 16'h112e,
      16'h1129, 16'h1128, 16'h1126, 16'h1124};
   localparam logic [NUM_REGS-1:0][15:0] REG_MAX = {
      16'h0007, 16'h0009, 16'h0002, 16'h0001, 16'h0001, 16'h0064,
      16'h07d0, 16'h07d0, 16'h07d0, 16'hffff, 16'hffff, 16'hffff,
      16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h03e8, 16'h03e8,
      16'h03e8, 16'h0fa0, 16'h0fa0, 16'h4e20};
   // ---------------------------------------------------------------
   // answers and codes
   // ---------------------------------------------------------------
   localparam logic [7:0]  EXC_NONE  = 8'h00;
   localparam logic [7:0]  EXC_FUNC  = 8'h01;
   localparam logic [7:0]  EXC_ADDR  = 8'h02;
   localparam logic [7:0]  EXC_VALUE = 8'h03;
   localparam logic [15:0] MEM_KEEP  = 16'h0001;
   localparam logic [15:0] CLR_RISE_STOP = 16'h0000;
   localparam logic [15:0] CLR_FALL_STOP = 16'h0001;
   localparam logic [15:0] CLR_RISE_RUN  = 16'h0002;
   localparam logic [15:0] FREQ_MAX  = 16'h0fa0;
   localparam logic [15:0] MON_FULL  = 16'h0064;
   localparam logic [31:0] PERMILLE  = 32'h0000_03e8;
   localparam int NUM_SOURCES = 10;
endpackage

// *** rtl/dtp_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtp_pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] level;
      logic [WIDTH-1:0] rise;
      logic [WIDTH-1:0] fall;
   } dtp_sync_state_t;
   dtp_sync_state_t q;
   dtp_sync_state_t d;
   logic [WIDTH-1:0] agree;
   // a change counts only once the second and third stages agree
   always_comb begin
      d       = q;
      agree   = ~(q.s2 ^ q.s3);
      d.s1    = pinIn;
      d.s2    = q.s1;
      d.s3    = q.s2;
      d.level = (agree & q.s3) | (~agree & q.level);
      d.rise  = agree & q.s3 & ~q.level;
      d.fall  = agree & ~q.s3 & q.level;
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign level = q.level;
   assign rise  = q.rise;
   assign fall  = q.fall;
endmodule // dtp_pin_sync
`default_nettype wire

// *** rtl/dtp_span_scale.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtp_span_scale
   import dtp_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic [15:0] inVal,
   input  wire logic [15:0] span,
   output logic      [15:0] scaled
);
   typedef struct packed {
      logic [15:0] scaled;
   } dtp_scale_state_t;
   dtp_scale_state_t q;
   dtp_scale_state_t d;
   logic [31:0] prod;
   logic [31:0] quot;
   // span is in tenths of a percent; result saturates rather than wraps
   always_comb begin
      d    = q;
      prod = inVal * span;
      quot = prod / PERMILLE;
      if (quot > 32'h0000_ffff) begin
         d.scaled = 16'hffff;
      end else begin
         d.scaled = quot[15:0];
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign scaled = q.scaled;
endmodule // dtp_span_scale
`default_nettype wire

// *** sim/dtp_net_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtp_net_master (
   input  wire logic        core_clk,
   output logic             netReq,
   output logic             netWrite,
   output logic      [15:0] netAddr,
   output logic      [15:0] netWrData,
   input  wire logic        netAck,
   input  wire logic [15:0] netRdData,
   input  wire logic [7:0]  netExcept
);
   // ------
   // one word per access
   // ------
   int gap = 0;
   initial begin
      {netReq, netWrite, netAddr, netWrData} = '0;
   end
   task automatic access(input logic w, input logic [15:0] a, d,
                         output logic [15:0] rd, output logic [7:0] ex);
      int n;
      ex = 8'hff;
      rd = 'x;
      repeat (gap) @(posedge core_clk);
      @(posedge core_clk);
      #1;
      netReq = 1'b1;
      netWrite = w;
      netAddr = a;
      netWrData = d;
      @(posedge core_clk);
      #1;
      netReq = 1'b0;
      for (n = 0; n < 4 && ex === 8'hff; n++) begin
         if (netAck === 1'b1) begin
            rd = netRdData;
            ex = netExcept;
         end else begin
            @(posedge core_clk);
            #1;
         end
      end
   endtask
endmodule // dtp_net_master
`default_nettype wire

// *** sim/dtp_terminal_regs_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtp_terminal_regs_props
   import dtp_pkg::*;
(
   input wire logic                   core_clk,
   input wire logic                   resetn,
   input wire logic                   netReq,
   input wire logic                   netWrite,
   input wire logic [15:0]            netAddr,
   input wire logic [15:0]            netWrData,
   input wire logic                   netAck,
   input wire logic [7:0]             netExcept,
   input wire logic [15:0]            loopSetpoint,
   input wire logic [15:0]            processFeedback,
   input wire logic                   deviationSignal,
   input wire logic [15:0]            analogMonitorOutput,
   input wire logic                   tripClear,
   input wire logic                   runStop,
   input wire logic [NUM_SOURCES-1:0] logicSources,
   input wire logic                   operandA,
   input wire logic                   operandB
);
   default clocking dcb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // ------
   // network answers
   // ------
   property p_rng(logic [15:0] a, logic [15:0] m);
      netReq && netWrite && netAddr == a |=>
         netAck && netExcept == (($past(netWrData) > m) ? EXC_VALUE : EXC_NONE);
   endproperty
   a_ovl_range: assert property (p_rng(16'h1124, 16'd20000))
      else $error("overload range");
   a_acc_range: assert property (p_rng(16'h1126, 16'd4000))
      else $error("arrival range");
   a_ofs_range: assert property (p_rng(16'h1145, 16'd100))
      else $error("offset range");
   a_clr_range: assert property (p_rng(16'h114a, 16'd2))
      else $error("reset mode range");
   a_opa_range: assert property (p_rng(16'h1150, 16'd9))
      else $error("operand range");
   a_ack_timing: assert property (netAck == $past(netReq))
      else $error("answer late");
   a_link_refused: assert property (netReq && netAddr >= 16'h1138 && netAddr <= 16'h113f
      |=> netAck && netExcept == EXC_ADDR) else $error("link reachable");
   a_debug_ro: assert property (netReq && netWrite && netAddr == 16'h1148
      |=> netExcept == EXC_FUNC) else $error("debug writable");
   // ------
   // outputs
   // ------
   a_stop_clears: assert property (runStop |-> tripClear)
      else $error("stop without clear");
   a_mon_ceiling: assert property (analogMonitorOutput <= 16'd100)
      else $error("monitor too high");
   a_oper_ones: assert property ((&logicSources)[*2] |-> operandA && operandB)
      else $error("operand missed");
   a_dev_zero: assert property ((loopSetpoint == processFeedback)[*2]
      |-> !deviationSignal) else $error("false deviation");
   c_refused: cover property (netAck && netExcept == EXC_VALUE);
   c_stop: cover property (runStop);
   c_clear_only: cover property (tripClear && !runStop);
endmodule // dtp_terminal_regs_props
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dtp_pkg::*;
   // ------
   // signals
   // ------
   logic core_clk, resetn = 1'b0, netReq, netWrite, netAck, kpReq = 1'b0, kpWrite = 1'b0;
   logic accelerating = 1'b0, decelerating = 1'b0, powerUp = 1'b0, resetPin = 1'b0;
   logic runMode = 1'b0, overloadSignal, arrivalSignal, deviationSignal, secondStageOut;
   logic tripClear, runStop, operandA, operandB;
   logic [1:0] incrementDecrementInputs = 2'b00;
   logic [7:0] netExcept, ex;
   logic [15:0] kpAddr = '0, kpWrData = '0, motorCurrent = '0, outputFreq = '0;
   logic [15:0] loopSetpoint = '0, processFeedback = '0, voltageFreqIn = '0, monitorIn = '0;
   logic [15:0] currentFreqInput = '0, thermalIn = '0, defaultFrequencySetting = '0;
   logic [15:0] netAddr, netWrData, netRdData, kpRdData, voltageFreqCmd, currentFreqCmd;
   logic [15:0] thermalTuned, analogMonitorOutput, freqSetpoint, rd;
   logic [NUM_SOURCES-1:0] logicSources = '0;
   int failures = 0, samples_checked = 0, cycles = 0;
   localparam logic [31:0] TBL [14] = '{32'h1124_4e20, 32'h1126_0fa0, 32'h1128_0fa0,
      32'h1129_03e8, 32'h112e_03e8, 32'h112f_03e8, 32'h1141_07d0, 32'h1142_07d0,
      32'h1144_07d0, 32'h1145_0064, 32'h1149_0001, 32'h114a_0002, 32'h1150_0009,
      32'h1151_0007};
   localparam int FB [8] = '{700, 500, 300, 500, 700, 399, 400, 601};
   localparam logic [7:0] SS = 8'h6c;
   localparam logic [7:0] DV = 8'hb5;
   dtp_terminal_regs i_dut (.*);
   dtp_net_master i_master (.*);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ------
   // helpers
   // ------
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 10000) begin
         failures++;
         summarize();
      end
   end
   task automatic chk(input logic [15:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic nw(input logic w, input logic [15:0] a, d, input logic [7:0] e);
      i_master.access(w, a, d, rd, ex);
      chk({8'h00, ex}, {8'h00, e});
   endtask
   task automatic kp(input logic w, input logic [15:0] a, d);
      kpReq = 1'b1;
      kpWrite = w;
      kpAddr = a;
      kpWrData = d;
      tk(1);
      kpReq = 1'b0;
      tk(1);
   endtask
   task automatic pu();
      powerUp = 1'b1;
      tk(1);
      powerUp = 1'b0;
      tk(3);
   endtask
   task automatic step(input logic [1:0] p);
      incrementDecrementInputs = p;
      tk(4);
      incrementDecrementInputs = 2'b00;
      tk(8);
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_ranges();
      logic [15:0] a, m;
      for (int i = 0; i < 14; i++) begin
         a = TBL[i][31:16];
         m = TBL[i][15:0];
         nw(1'b0, a, 16'h0000, EXC_NONE);
         chk(rd, 16'h0000);
         nw(1'b1, a, m, EXC_NONE);
         nw(1'b1, a, m + 16'h0001, EXC_VALUE);
         nw(1'b0, a, 16'h0000, EXC_NONE);
         chk(rd, m);
      end
      nw(1'b0, 16'h113a, 16'h0000, EXC_ADDR);
      nw(1'b0, 16'h1000, 16'h0000, EXC_ADDR);
      $display("test ranges done");
   endtask
   task automatic t_access();
      i_master.gap = 2;
      for (int a = 'h1138; a <= 'h113f; a++) nw(1'b1, 16'(a), 16'h0001, EXC_ADDR);
      i_master.gap = 0;
      kp(1'b0, 16'h1139, 16'h0000);
      chk(kpRdData, 16'h0000);
      kp(1'b1, 16'h1139, 16'h0005);
      kp(1'b0, 16'h1139, 16'h0000);
      chk(kpRdData, 16'h0005);
      nw(1'b0, 16'h1139, 16'h0000, EXC_ADDR);
      nw(1'b1, 16'h1148, 16'h0001, EXC_FUNC);
      nw(1'b0, 16'h1148, 16'h0000, EXC_NONE);
      chk(rd, 16'h0000);
      kp(1'b1, 16'h1148, 16'h0001);
      nw(1'b0, 16'h1148, 16'h0000, EXC_NONE);
      chk(rd, 16'h0001);
      $display("test access done");
   endtask
   task automatic t_loop();
      nw(1'b1, 16'h112e, 16'd600, EXC_NONE);
      nw(1'b1, 16'h112f, 16'd400, EXC_NONE);
      nw(1'b1, 16'h1129, 16'd100, EXC_NONE);
      loopSetpoint = 16'd500;
      for (int i = 0; i < 8; i++) begin
         processFeedback = 16'(FB[i]);
         tk(3);
         chk({15'h0, secondStageOut}, {15'h0, SS[i]});
         chk({15'h0, deviationSignal}, {15'h0, DV[i]});
      end
      $display("test loop done");
   endtask
   task automatic t_levels();
      nw(1'b1, 16'h1124, 16'd5000, EXC_NONE);
      nw(1'b1, 16'h1126, 16'd300, EXC_NONE);
      nw(1'b1, 16'h1128, 16'd100, EXC_NONE);
      motorCurrent = 16'd5001;
      accelerating = 1'b1;
      outputFreq = 16'd300;
      tk(3);
      chk({14'h0, overloadSignal, arrivalSignal}, 16'h0003);
      motorCurrent = 16'd5000;
      outputFreq = 16'd299;
      tk(3);
      chk({14'h0, overloadSignal, arrivalSignal}, 16'h0000);
      accelerating = 1'b0;
      decelerating = 1'b1;
      outputFreq = 16'd100;
      tk(3);
      chk({15'h0, arrivalSignal}, 16'h0001);
      outputFreq = 16'd101;
      tk(3);
      chk({15'h0, arrivalSignal}, 16'h0000);
      $display("test levels done");
   endtask
   task automatic t_scale();
      nw(1'b1, 16'h1141, 16'd2000, EXC_NONE);
      nw(1'b1, 16'h1142, 16'd500, EXC_NONE);
      nw(1'b1, 16'h1144, 16'd1500, EXC_NONE);
      nw(1'b1, 16'h1145, 16'd30, EXC_NONE);
      voltageFreqIn = 16'd1000;
      currentFreqInput = 16'd1000;
      thermalIn = 16'd200;
      monitorIn = 16'd50;
      tk(4);
      chk(voltageFreqCmd, 16'd2000);
      chk(currentFreqCmd, 16'd500);
      chk(thermalTuned, 16'd300);
      chk(analogMonitorOutput, 16'd80);
      monitorIn = 16'd90;
      tk(4);
      chk(analogMonitorOutput, 16'd100);
      $display("test scale done");
   endtask
   task automatic t_memory();
      nw(1'b1, 16'h1149, 16'h0000, EXC_NONE);
      defaultFrequencySetting = 16'd1234;
      pu();
      chk(freqSetpoint, 16'd1234);
      step(2'b01);
      chk(freqSetpoint, 16'd1235);
      pu();
      chk(freqSetpoint, 16'd1234);
      nw(1'b1, 16'h1149, 16'h0001, EXC_NONE);
      step(2'b01);
      pu();
      chk(freqSetpoint, 16'd1235);
      step(2'b10);
      chk(freqSetpoint, 16'd1234);
      $display("test memory done");
   endtask
   task automatic t_trip();
      logic [15:0] r, f, s;
      runMode = 1'b1;
      for (int m = 0; m < 3; m++) begin
         nw(1'b1, 16'h114a, 16'(m), EXC_NONE);
         r = 16'h0000;
         f = 16'h0000;
         s = 16'h0000;
         resetPin = 1'b1;
         repeat (10) begin
            tk(1);
            r = r + tripClear;
            s = s + runStop;
         end
         resetPin = 1'b0;
         repeat (10) begin
            tk(1);
            f = f + tripClear;
            s = s + runStop;
         end
         chk(r, 16'(m != 1));
         chk(f, 16'(m == 1));
         chk(s, 16'(m != 2));
      end
      $display("test trip done");
   endtask
   task automatic t_oper();
      nw(1'b1, 16'h1150, 16'd3, EXC_NONE);
      nw(1'b1, 16'h1151, 16'd7, EXC_NONE);
      logicSources = 10'h008;
      tk(3);
      chk({14'h0, operandA, operandB}, 16'h0002);
      logicSources = 10'h080;
      tk(3);
      chk({14'h0, operandA, operandB}, 16'h0001);
      nw(1'b1, 16'h1150, 16'd9, EXC_NONE);
      logicSources = 10'h3ff;
      tk(3);
      chk({14'h0, operandA, operandB}, 16'h0003);
      $display("test operands done");
   endtask
   initial begin
      tk(3);
      resetn = 1'b1;
      t_ranges();
      t_access();
      t_loop();
      t_levels();
      t_scale();
      t_memory();
      t_trip();
      t_oper();
      summarize();
   end
endmodule // tb_top
bind dtp_terminal_regs dtp_terminal_regs_props i_props (.*);
`default_nettype wire
